/* File: hdl/iormf_defs.svh */
// offsets, field positions and reset values of the peripheral register bank
`ifndef IORMF_DEFS_SVH
`define IORMF_DEFS_SVH
`define IORMF_ADDR_W        8
`define IORMF_OFF_PINS      8'he0
`define IORMF_OFF_TAPS      8'he3
`define IORMF_OFF_CNT0      8'he4
`define IORMF_OFF_CNT1      8'he5
`define IORMF_OFF_CNT2      8'he6
`define IORMF_OFF_CNT3      8'he7
`define IORMF_OFF_PIN_EN    8'he8
`define IORMF_OFF_TICK_EN   8'heb
`define IORMF_OFF_CONV_EN   8'hec
`define IORMF_OFF_PIN_PEND  8'hed
`define IORMF_OFF_TICK_PEND 8'hef
`define IORMF_TICK2_BIT     2
`define IORMF_TICK8_BIT     1
`define IORMF_TICK32_BIT    0
`define IORMF_RST_NIB       4'h0
`define IORMF_RST_TICK      3'h0
`endif

/* File: hdl/iormf_pkg.sv */
// types shared by the peripheral register bank
package iormf_pkg;
  typedef logic [3:0] iormf_nib_t;
  typedef logic [2:0] iormf_tick_t;
endpackage

/* File: hdl/iormf_flag.sv */
// one sticky event flag that clears after a read
`timescale 1ns/1ps
module iormf_flag (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // event and clear
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      flag_o
);
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule

/* File: hdl/iormf_bank.sv */
// peripheral register bank: ports, timer taps, counter, masks, factor flags
// Summary of operation
// - 0e0 reads the four input pin levels, high is 1, writes are ignored.
// - 0e3 reads the timer taps, bit3 2 Hz, bit2 4 Hz, bit1 8 Hz, bit0 16 Hz.
// - 0e4..0e7 read and write the 16-bit counter, lsb in bit0 of 0e4.
// - the counter msb is bit3 of 0e7.
// - 0e8 holds four pin interrupt enables, bit n for pin n, reset 0.
// - 0eb holds tick enables 2 Hz bit2, 8 Hz bit1, 32 Hz bit0; bit3 reads 0.
// - 0ec bit0 is the converter interrupt enable, reset 0, upper bits read 0.
// - 0ed bit0 is the pin interrupt factor flag, reset 0.
// - 0ef holds tick factor flags 2 Hz bit2, 8 Hz bit1, 32 Hz bit0.
// - a factor flag clears once a read of its register has returned it, unless its event arrives in that same cycle.
// - unimplemented mask and flag bits read 0.
// - reset clears every enable and every factor flag.
`timescale 1ns/1ps
`include "iormf_defs.svh"
module iormf_bank (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // cpu data memory access
  input  wire logic [7:0]             addr_i,
  input  wire logic                   rd_i,
  input  wire logic                   wr_i,
  input  wire logic [3:0]             wdata_i,
  output logic      [3:0]             rdata_o,
  // pins and peripheral state
  input  wire logic [3:0]             input_pin_bits_i,
  input  wire logic [3:0]             timer_tap_bits_i,
  input  wire logic                   pin_event_i,
  input  wire logic                   tick2hz_event_i,
  input  wire logic                   tick8hz_event_i,
  input  wire logic                   tick32hz_event_i,
  input  wire logic                   converter_pending_i,
  // counter engine: load pulse with value, live value back
  output logic                        cnt_load_o,
  output logic      [15:0]            cnt_load_val_o,
  input  wire logic [15:0]            updown_count_bits_i,
  // mask outputs and interrupt request
  output logic      [3:0]             pin_irq_enable_bits_o,
  output logic      [2:0]             tick_irq_enable_o,
  output logic                        converter_irq_enable_o,
  output logic                        irq_o
);
  iormf_pkg::iormf_nib_t  pin_en_r;
  iormf_pkg::iormf_tick_t tick_en_r;
  logic                   conv_en_r;
  logic                   pin_pend;
  iormf_pkg::iormf_tick_t tick_pend;
  iormf_pkg::iormf_nib_t  rdata_nxt;
  logic [15:0]            load_nxt;
  logic                   rd_pin_pend;
  logic                   rd_tick_pend;
  logic                   irq_nxt;
  logic                   sel_pin_en;
  logic                   sel_tick_en;
  logic                   sel_conv_en;
  logic                   sel_cnt;

  // cpu accesses are plain memory cycles on addr/rd/wr
  assign rd_pin_pend  = rd_i && (addr_i == `IORMF_OFF_PIN_PEND);
  assign rd_tick_pend = rd_i && (addr_i == `IORMF_OFF_TICK_PEND);
  // write decodes, one per target register
  assign sel_pin_en   = addr_i == `IORMF_OFF_PIN_EN;
  assign sel_tick_en  = addr_i == `IORMF_OFF_TICK_EN;
  assign sel_conv_en  = addr_i == `IORMF_OFF_CONV_EN;
  // the four counter nibbles share one aligned block of addresses
  assign sel_cnt      = addr_i[7:2] == 6'(`IORMF_OFF_CNT0 >> 2);

  // pin enables
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_en_r <= `IORMF_RST_NIB;
    end else if (wr_i && sel_pin_en) begin
      pin_en_r <= wdata_i;
    end
  end

  // tick enables; bit3 has no storage, so a write there is lost on purpose
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_en_r <= `IORMF_RST_TICK;
    end else if (wr_i && sel_tick_en) begin
      tick_en_r <= wdata_i[2:0];
    end
  end

  // converter enable; only bit0 is stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_en_r <= 1'b0;
    end else if (wr_i && sel_conv_en) begin
      conv_en_r <= wdata_i[0];
    end
  end

  // factor flags: the clear follows the read that returned the value
  iormf_flag u_pin_flag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (pin_event_i),
    .clr_i  (rd_pin_pend),
    .flag_o (pin_pend)
  );
  iormf_flag u_t2_flag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (tick2hz_event_i),
    .clr_i  (rd_tick_pend),
    .flag_o (tick_pend[`IORMF_TICK2_BIT])
  );
  iormf_flag u_t8_flag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (tick8hz_event_i),
    .clr_i  (rd_tick_pend),
    .flag_o (tick_pend[`IORMF_TICK8_BIT])
  );
  iormf_flag u_t32_flag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (tick32hz_event_i),
    .clr_i  (rd_tick_pend),
    .flag_o (tick_pend[`IORMF_TICK32_BIT])
  );

  // read mux; unmapped addresses read 0
  always_comb begin
    rdata_nxt = 4'h0;
    unique case (addr_i)
      `IORMF_OFF_PINS:      rdata_nxt = input_pin_bits_i;
      `IORMF_OFF_TAPS:      rdata_nxt = timer_tap_bits_i;
      `IORMF_OFF_CNT0:      rdata_nxt = updown_count_bits_i[3:0];
      `IORMF_OFF_CNT1:      rdata_nxt = updown_count_bits_i[7:4];
      `IORMF_OFF_CNT2:      rdata_nxt = updown_count_bits_i[11:8];
      `IORMF_OFF_CNT3:      rdata_nxt = updown_count_bits_i[15:12];
      `IORMF_OFF_PIN_EN:    rdata_nxt = pin_en_r;
      `IORMF_OFF_TICK_EN:   rdata_nxt = {1'b0, tick_en_r};
      `IORMF_OFF_CONV_EN:   rdata_nxt = {3'h0, conv_en_r};
      `IORMF_OFF_PIN_PEND:  rdata_nxt = {3'h0, pin_pend};
      `IORMF_OFF_TICK_PEND: rdata_nxt = {1'b0, tick_pend};
      default:              rdata_nxt = 4'h0;
    endcase
  end

  // read data registered: it leaves the cycle after rd_i, the same edge clears the flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 4'h0;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end
  end

  // counter nibble write merges into the live value
  always_comb begin
    load_nxt = updown_count_bits_i;
    unique case (addr_i)
      `IORMF_OFF_CNT0: load_nxt[3:0]   = wdata_i;
      `IORMF_OFF_CNT1: load_nxt[7:4]   = wdata_i;
      `IORMF_OFF_CNT2: load_nxt[11:8]  = wdata_i;
      `IORMF_OFF_CNT3: load_nxt[15:12] = wdata_i;
      default:         load_nxt = updown_count_bits_i;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_load_o     <= 1'b0;
      cnt_load_val_o <= 16'h0000;
    end else begin
      cnt_load_o     <= wr_i && sel_cnt;
      cnt_load_val_o <= load_nxt;
    end
  end

  // interrupt request; pins reach it only through their factor flag, the per-pin
  // level compare against the enables lives in the pin comparator outside
  assign irq_nxt = (pin_pend & |pin_en_r) | (|(tick_pend & tick_en_r))
                 | (converter_pending_i & conv_en_r);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_nxt;
    end
  end

  // enables copied out, one cycle behind the registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_irq_enable_bits_o  <= 4'h0;
      tick_irq_enable_o      <= 3'h0;
      converter_irq_enable_o <= 1'b0;
    end else begin
      pin_irq_enable_bits_o  <= pin_en_r;
      tick_irq_enable_o      <= tick_en_r;
      converter_irq_enable_o <= conv_en_r;
    end
  end

  // assertions
  a_pend_clear_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_pin_pend && !pin_event_i |=> !pin_pend)
    else $error("pin flag not cleared");
  a_tick_clear_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_tick_pend && !tick2hz_event_i |=> !tick_pend[2])
    else $error("tick flag kept");
  a_t8_clear_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_tick_pend && !tick8hz_event_i |=> !tick_pend[1])
    else $error("8 Hz flag kept");
  a_t32_clear_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_tick_pend && !tick32hz_event_i |=> !tick_pend[0])
    else $error("32 Hz flag kept");
  a_pin_set_wins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_pin_pend && pin_event_i |=> pin_pend)
    else $error("pin event lost under read");
  a_tick_set_wins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_tick_pend && tick2hz_event_i |=> tick_pend[2])
    else $error("tick event lost under read");
  a_event_sets_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick8hz_event_i |=> tick_pend[1])
    else $error("event lost");
  a_t2_event_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick2hz_event_i |=> tick_pend[2])
    else $error("2 Hz event lost");
  a_t32_event_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick32hz_event_i |=> tick_pend[0])
    else $error("32 Hz event lost");
  a_pin_event_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pin_event_i |=> pin_pend)
    else $error("pin event lost");
  a_pin_flag_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pin_pend && !rd_pin_pend |=> pin_pend)
    else $error("pin flag dropped unread");
  a_tick_flag_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick_pend[1] && !rd_tick_pend |=> tick_pend[1])
    else $error("tick flag dropped unread");
  a_pin_read_data: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_PINS |=> rdata_o == $past(input_pin_bits_i))
    else $error("pin read wrong");
  a_tap_read_data: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_TAPS |=> rdata_o == $past(timer_tap_bits_i))
    else $error("tap read wrong");
  a_lsb_read_data: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_CNT0 |=> rdata_o == $past(updown_count_bits_i[3:0]))
    else $error("lsb nibble read wrong");
  a_mid_read_data: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_CNT1 |=> rdata_o == $past(updown_count_bits_i[7:4]))
    else $error("second nibble read wrong");
  a_msb_read_data: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_CNT3 |=> rdata_o[3] == $past(updown_count_bits_i[15]))
    else $error("msb read wrong");
  a_pin_en_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_PIN_EN |=> rdata_o == $past(pin_en_r))
    else $error("pin enable read wrong");
  a_tick_en_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_TICK_EN |=> rdata_o == {1'b0, $past(tick_en_r)})
    else $error("tick enable read wrong");
  a_pin_pend_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_PIN_PEND |=> rdata_o[0] == $past(pin_pend))
    else $error("pin flag read wrong");
  a_tick_pend_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_TICK_PEND |=> rdata_o[2:0] == $past(tick_pend))
    else $error("tick flags read wrong");
  a_zero_upper_bits: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_PIN_PEND |=> rdata_o[3:1] == 3'h0)
    else $error("upper bits not 0");
  a_tick_top_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_TICK_PEND |=> !rdata_o[3])
    else $error("tick flag top bit not 0");
  a_conv_top_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == `IORMF_OFF_CONV_EN |=> rdata_o[3:1] == 3'h0)
    else $error("converter upper bits not 0");
  a_rdata_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  a_load_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && sel_cnt |=> cnt_load_o)
    else $error("counter load missing");
  a_load_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(wr_i && sel_cnt) |=> !cnt_load_o)
    else $error("spurious counter load");
  a_lsb_load_val: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `IORMF_OFF_CNT0 |=> cnt_load_val_o[3:0] == $past(wdata_i))
    else $error("lsb nibble load wrong");
  a_msb_load_val: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `IORMF_OFF_CNT3 |=> cnt_load_val_o[15:12] == $past(wdata_i))
    else $error("msb nibble load wrong");
  a_mask_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `IORMF_OFF_PIN_EN |=> ##1 pin_irq_enable_bits_o == $past(wdata_i, 2))
    else $error("mask write lost");
  a_tick_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `IORMF_OFF_TICK_EN |=> ##1 tick_irq_enable_o == $past(wdata_i[2:0], 2))
    else $error("tick enable lost");
  a_conv_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `IORMF_OFF_CONV_EN |=> ##1 converter_irq_enable_o == $past(wdata_i[0], 2))
    else $error("conv enable lost");
  a_irq_tick: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick_pend[0] && tick_en_r[0] |=> irq_o)
    else $error("irq missing");
  a_irq_pin: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pin_pend && |pin_en_r |=> irq_o)
    else $error("pin irq missing");
  a_irq_conv: assert property (
    @(posedge clk_i) disable iff (rst_i)
    converter_pending_i && conv_en_r |=> irq_o)
    else $error("converter irq missing");
  a_irq_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !pin_pend && tick_pend == 3'h0 && !converter_pending_i |=> !irq_o)
    else $error("spurious irq");
  a_reset_clear: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> !pin_pend && tick_en_r == 3'h0)
    else $error("reset state wrong");
  a_reset_masks: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> pin_en_r == 4'h0 && !conv_en_r && tick_pend == 3'h0)
    else $error("reset masks wrong");
endmodule

/* File: test/iormf_cpu.sv */
// cpu core model issuing data memory reads and writes
`timescale 1ns/1ps
module iormf_cpu (
  // clock
  input  wire logic       clk_i,
  // data memory access
  output logic      [7:0] addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [3:0] wdata_o
);
  initial begin
    addr_o  = 8'h00;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 4'h0;
  end

  // one access per call; a gap cycle follows, so rd and wr never meet
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    rd_o    <= ~w;
    wr_o    <= w;
    @(posedge clk_i);
    rd_o    <= 1'b0;
    wr_o    <= 1'b0;
    // released lines do not keep the last value
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
endmodule

/* File: test/iormf_bank_tb.sv */
// self-checking bench of the peripheral register bank
`timescale 1ns/1ps
`include "iormf_defs.svh"
module iormf_bank_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i;
  logic        rd_i;
  logic        wr_i;
  logic        rd_d = 1'b0;
  logic [3:0]  wdata_i, rdata_o, pin_irq_enable_bits_o;
  logic [3:0]  input_pin_bits_i = 4'h0, timer_tap_bits_i = 4'h0;
  logic        pin_event_i = 1'b0, tick2hz_event_i = 1'b0, tick8hz_event_i = 1'b0;
  logic        tick32hz_event_i = 1'b0, converter_pending_i = 1'b0;
  logic        cnt_load_o, converter_irq_enable_o, irq_o;
  logic [15:0] cnt_load_val_o, updown_count_bits_i = 16'h0000, exp_ld, r = 16'hc616;
  logic [2:0]  tick_irq_enable_o;
  logic [3:0]  exp_q[$];
  int          n_mismatch = 0, samples_checked = 0, n_load = 0;

  iormf_bank i_dut (.clk_i, .rst_i, .addr_i, .rd_i, .wr_i, .wdata_i, .rdata_o,
    .input_pin_bits_i, .timer_tap_bits_i, .pin_event_i, .tick2hz_event_i,
    .tick8hz_event_i, .tick32hz_event_i, .converter_pending_i, .cnt_load_o,
    .cnt_load_val_o, .updown_count_bits_i, .pin_irq_enable_bits_o,
    .tick_irq_enable_o, .converter_irq_enable_o, .irq_o);
  iormf_cpu i_cpu (.clk_i, .addr_o(addr_i), .rd_o(rd_i), .wr_o(wr_i), .wdata_o(wdata_i));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    exp_q.push_back(e);
    i_cpu.acc(1'b0, a, 4'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    i_cpu.acc(1'b1, a, d);
  endtask
  // events ordered pin, 2 Hz, 8 Hz, 32 Hz
  task automatic pulse(input logic [3:0] e);
    @(posedge clk_i);
    {pin_event_i, tick2hz_event_i, tick8hz_event_i, tick32hz_event_i} <= e;
    @(posedge clk_i);
    {pin_event_i, tick2hz_event_i, tick8hz_event_i, tick32hz_event_i} <= 4'h0;
  endtask
  task automatic irq(input logic e);
    repeat (3) @(negedge clk_i);
    chk("irq", {15'h0, e}, {15'h0, irq_o});
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // read data is valid one cycle after the read edge and stands until the next read
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin
    if (rd_d) chk("rdata", {12'h0, exp_q.pop_front()}, {12'h0, rdata_o});
    if (cnt_load_o) begin
      n_load++;
      chk("cnt_load_val", exp_ld, cnt_load_val_o);
    end
  end

  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`IORMF_OFF_PIN_EN, 4'h0);
    rd(`IORMF_OFF_TICK_EN, 4'h0);
    rd(`IORMF_OFF_CONV_EN, 4'h0);
    rd(`IORMF_OFF_PIN_PEND, 4'h0);
    rd(`IORMF_OFF_TICK_PEND, 4'h0);
    for (int k = 0; k < 4; k++) begin
      r = lfsr(r);
      input_pin_bits_i    <= r[3:0];
      timer_tap_bits_i    <= r[7:4];
      updown_count_bits_i <= r;
      rd(`IORMF_OFF_PINS, r[3:0]);
      rd(`IORMF_OFF_TAPS, r[7:4]);
      for (int j = 0; j < 4; j++) rd(`IORMF_OFF_CNT0 + 8'(j), r[4*j+:4]);
      exp_ld = r;
      exp_ld[4*k+:4] = r[11:8];
      wr(`IORMF_OFF_CNT0 + 8'(k), r[11:8]);
      wr(`IORMF_OFF_PINS, ~r[3:0]);
      rd(`IORMF_OFF_PINS, r[3:0]);
      wr(`IORMF_OFF_PIN_EN, r[3:0]);
      rd(`IORMF_OFF_PIN_EN, r[3:0]);
      wr(`IORMF_OFF_TICK_EN, r[7:4]);
      rd(`IORMF_OFF_TICK_EN, {1'b0, r[6:4]});
      wr(`IORMF_OFF_CONV_EN, r[11:8]);
      rd(`IORMF_OFF_CONV_EN, {3'h0, r[8]});
      chk("enables", {8'h0, r[3:0], r[6:4], r[8]},
          {8'h0, pin_irq_enable_bits_o, tick_irq_enable_o, converter_irq_enable_o});
    end
    chk("load_count", 16'h4, 16'(n_load));
    wr(`IORMF_OFF_CONV_EN, 4'h0);
    wr(`IORMF_OFF_PIN_EN, 4'hf);
    wr(`IORMF_OFF_TICK_EN, 4'h7);
    pulse(4'hf);
    irq(1'b1);
    rd(`IORMF_OFF_PIN_PEND, 4'h1);
    rd(`IORMF_OFF_PIN_PEND, 4'h0);
    rd(`IORMF_OFF_TICK_PEND, 4'h7);
    irq(1'b0);
    for (int i = 0; i < 3; i++) begin
      pulse({1'b0, 3'h1 << i});
      rd(`IORMF_OFF_TICK_PEND, {1'b0, 3'h1 << i});
    end
    wr(`IORMF_OFF_TICK_EN, 4'h0);
    pulse(4'h7);
    irq(1'b0);
    rd(`IORMF_OFF_TICK_PEND, 4'h7);
    pulse(4'h8);
    irq(1'b1);
    rd(`IORMF_OFF_PIN_PEND, 4'h1);
    irq(1'b0);
    wr(`IORMF_OFF_PIN_EN, 4'h0);
    pulse(4'h8);
    irq(1'b0);
    rd(`IORMF_OFF_PIN_PEND, 4'h1);
    converter_pending_i <= 1'b1;
    wr(`IORMF_OFF_CONV_EN, 4'h1);
    irq(1'b1);
    wr(`IORMF_OFF_CONV_EN, 4'h0);
    irq(1'b0);
    wr(`IORMF_OFF_PIN_EN, 4'hf);
    wr(`IORMF_OFF_TICK_EN, 4'h7);
    wr(`IORMF_OFF_CONV_EN, 4'h1);
    pulse(4'hf);
    irq(1'b1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    irq(1'b0);
    rd(`IORMF_OFF_PIN_EN, 4'h0);
    rd(`IORMF_OFF_TICK_EN, 4'h0);
    rd(`IORMF_OFF_CONV_EN, 4'h0);
    rd(`IORMF_OFF_PIN_PEND, 4'h0);
    rd(`IORMF_OFF_TICK_PEND, 4'h0);
    chk("enables", 16'h0000,
        {8'h0, pin_irq_enable_bits_o, tick_irq_enable_o, converter_irq_enable_o});
    rd(8'he1, 4'h0);
    repeat (3) @(posedge clk_i);
    summarize();
  end
endmodule
